// ==== core/iwc_core.sv ====
// Purpose: Interrupt gating, sleep wake, pin edge detect and context shadowing.
// Assumes: Single 50 MHz clock, APB slave with zero wait states.
// Notes: The external pin is asynchronous and passes three flip-flops.
`timescale 1ns/1ps
module iwc_core #(
	// Peripheral sources that run without the system clock.
	parameter logic [7:0] P_WAKE_MASK = 8'hC9
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_arst_n,
	// APB slave.
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [iwc_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Interrupt sources.
	input wire logic i_ext_pin,
	input wire logic i_timer0_ovf,
	input wire logic i_pin_change,
	input wire logic [7:0] i_periph_flags,
	// Core sequencer.
	input wire logic i_sleep_enter,
	input wire logic i_instr_done,
	input wire logic i_irq_entry,
	input wire logic [iwc_pkg::PC_W-1:0] i_return_pc,
	input wire logic i_irq_exit,
	input wire logic [7:0] i_ctx_live [iwc_pkg::CTX_N],
	// Requests and context back to the core.
	output logic o_irq,
	output logic o_sleeping,
	output logic o_wake,
	output logic o_stack_push,
	output logic [iwc_pkg::PC_W-1:0] o_stack_pc,
	output logic o_restore_valid,
	output logic [7:0] o_ctx_restore [iwc_pkg::CTX_N]
);
	// ========================================================
	// Declarations.
	logic [7:0] ctrl, next_ctrl;
	logic [7:0] pie, next_pie;
	logic edge_sel, next_edge_sel;
	logic [7:0] shadow [iwc_pkg::CTX_N];
	logic [7:0] next_shadow [iwc_pkg::CTX_N];
	logic sync1, sync2, sync3, next_sync1, next_sync2, next_sync3;
	logic pin_level, next_pin_level, pin_primed, next_pin_primed;
	logic [2:0] fill, next_fill;
	logic ext_edge;
	iwc_pkg::iwc_state_e state, next_state;
	logic [7:0] snap_ctrl, next_snap_ctrl, snap_pie, next_snap_pie;
	logic next_wake;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic [11:0] idx;
	logic aligned, apb_wr, apb_setup, shadow_hit;
	logic pending, wake_src;

	// ========================================================
	// APB decode.
	// Read data is latched in the setup cycle so the access ends at once.
	assign o_pready = 1'b1;
	assign idx = i_paddr[iwc_pkg::ADDR_W-1:2];
	assign aligned = (i_paddr[1:0] == 2'b00);
	assign apb_setup = i_psel && !i_penable;
	assign apb_wr = i_psel && i_penable && i_pwrite && aligned;
	assign shadow_hit = (idx[11:3] == iwc_pkg::SHADOW_IDX[11:3]);

	always_comb begin
		next_prdata = iwc_pkg::UNMAPPED_DATA;
		next_pslverr = 1'b0;
		if (apb_setup) begin
			if (!aligned) begin
				next_pslverr = 1'b1;
			end else if (idx == iwc_pkg::IRQ_CTRL_IDX) begin
				next_prdata = {24'h00_0000, ctrl};
			end else if (idx == iwc_pkg::PIE_IDX) begin
				next_prdata = {24'h00_0000, pie & iwc_pkg::PIE_MASK}; // RL13
			end else if (idx == iwc_pkg::OPTION_IDX) begin
				next_prdata = {24'h00_0000, 1'b0, edge_sel, 6'h00};
			end else if (shadow_hit) begin
				next_prdata = {24'h00_0000, shadow[idx[2:0]]}; // RL12
			end else begin
				next_pslverr = 1'b1;
			end
		end else begin
			next_prdata = o_prdata;
			next_pslverr = o_pslverr;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_prdata <= iwc_pkg::UNMAPPED_DATA;
			o_pslverr <= 1'b0;
		end else begin
			o_prdata <= next_prdata;
			o_pslverr <= next_pslverr;
		end
	end

	// ========================================================
	// External pin synchroniser and edge detect.
	// The first stable level after the chain has filled only primes the
	// detector, so a pin that idles high does not fake a rising edge.
	always_comb begin
		next_sync1 = i_ext_pin;
		next_sync2 = sync1;
		next_sync3 = sync2;
		next_fill = {fill[1:0], 1'b1};
		next_pin_level = pin_level;
		next_pin_primed = pin_primed;
		ext_edge = 1'b0;
		// Reset values in the chain are not pin levels, so wait for the fill.
		if (fill[2] && (sync2 == sync3)) begin
			next_pin_level = sync3;
			next_pin_primed = 1'b1;
			ext_edge = pin_primed && (sync3 != pin_level) && (sync3 == edge_sel); // RL5 RL6
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
			fill <= 3'b000;
			pin_level <= 1'b0;
			pin_primed <= 1'b0;
		end else begin
			sync1 <= next_sync1;
			sync2 <= next_sync2;
			sync3 <= next_sync3;
			fill <= next_fill;
			pin_level <= next_pin_level;
			pin_primed <= next_pin_primed;
		end
	end

	// ========================================================
	// Control, enable and shadow registers.
	// Hardware flag sets are applied after the software clear, so a set wins.
	always_comb begin
		next_ctrl = ctrl;
		next_pie = pie;
		next_edge_sel = edge_sel;
		next_shadow = shadow;
		if (apb_wr) begin
			if (idx == iwc_pkg::IRQ_CTRL_IDX) begin
				next_ctrl = (i_pwdata[7:0] & ~iwc_pkg::FLAG_MASK) |
					(ctrl & iwc_pkg::FLAG_MASK & ~i_pwdata[7:0]);
			end else if (idx == iwc_pkg::PIE_IDX) begin
				next_pie = i_pwdata[7:0] & iwc_pkg::PIE_MASK; // RL13
			end else if (idx == iwc_pkg::OPTION_IDX) begin
				next_edge_sel = i_pwdata[iwc_pkg::EDGE_BIT]; // RL6
			end else if (shadow_hit) begin
				next_shadow[idx[2:0]] = i_pwdata[7:0]; // RL12
			end
		end
		if (ext_edge) begin
			next_ctrl[iwc_pkg::PIN_FLAG_BIT] = 1'b1; // RL7
		end
		if (i_timer0_ovf) begin
			next_ctrl[iwc_pkg::T0IF_BIT] = 1'b1;
		end
		if (i_pin_change) begin
			next_ctrl[iwc_pkg::CHG_FLAG_BIT] = 1'b1;
		end
		// Entry masks further requests until the handler returns.
		if (i_irq_entry) begin
			next_ctrl[iwc_pkg::GLB_EN_BIT] = 1'b0;
			next_shadow = i_ctx_live; // RL10
			next_shadow[iwc_pkg::CTX_STATUS] =
				i_ctx_live[iwc_pkg::CTX_STATUS] & iwc_pkg::STATUS_SAVE_MASK; // RL10
		end else if (i_irq_exit) begin
			next_ctrl[iwc_pkg::GLB_EN_BIT] = 1'b1;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl <= iwc_pkg::IRQ_CTRL_RST;
			pie <= iwc_pkg::PIE_RST;
			edge_sel <= iwc_pkg::EDGE_RST;
			shadow <= '{default: iwc_pkg::CTX_RST};
		end else begin
			ctrl <= next_ctrl;
			pie <= next_pie;
			edge_sel <= next_edge_sel;
			shadow <= next_shadow;
		end
	end

	// ========================================================
	// Request gating.
	// Flags stay set until software clears them, so an unhandled one re-fires.
	assign pending = (ctrl[iwc_pkg::T0IE_BIT] && ctrl[iwc_pkg::T0IF_BIT]) ||
		(ctrl[iwc_pkg::INTE_BIT] && ctrl[iwc_pkg::PIN_FLAG_BIT]) || // RL5
		(ctrl[iwc_pkg::CHG_EN_BIT] && ctrl[iwc_pkg::CHG_FLAG_BIT]) ||
		(ctrl[iwc_pkg::PER_EN_BIT] && |(pie & i_periph_flags)); // RL14 RL15
	assign o_irq = ctrl[iwc_pkg::GLB_EN_BIT] && pending && (state == iwc_pkg::RUN); // RL8
	assign o_sleeping = (state == iwc_pkg::SLEEP);
	// Timer0 runs on the system clock and is left out of the wake set.
	assign wake_src = (snap_ctrl[iwc_pkg::INTE_BIT] && ctrl[iwc_pkg::PIN_FLAG_BIT]) || // RL1
		(snap_ctrl[iwc_pkg::CHG_EN_BIT] && ctrl[iwc_pkg::CHG_FLAG_BIT]) ||
		(snap_ctrl[iwc_pkg::PER_EN_BIT] &&
		|(snap_pie & P_WAKE_MASK & i_periph_flags)); // RL1 RL2 RL14

	// ========================================================
	// Sleep and wake sequencing.
	always_comb begin
		next_state = state;
		next_snap_ctrl = snap_ctrl;
		next_snap_pie = snap_pie;
		next_wake = 1'b0;
		case (state)
			iwc_pkg::RUN: begin
				if (i_sleep_enter) begin
					next_snap_ctrl = ctrl; // RL1
					next_snap_pie = pie; // RL1
					next_state = iwc_pkg::SLEEP;
				end
			end
			iwc_pkg::SLEEP: begin
				if (wake_src) begin
					next_wake = 1'b1;
					next_state = ctrl[iwc_pkg::GLB_EN_BIT] ? iwc_pkg::WAKE_ONE : iwc_pkg::RUN; // RL3
				end
			end
			iwc_pkg::WAKE_ONE: begin
				if (i_instr_done) begin
					next_state = iwc_pkg::RUN; // RL4
				end
			end
			default: begin
				next_state = iwc_pkg::RUN;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state <= iwc_pkg::RUN;
			snap_ctrl <= iwc_pkg::IRQ_CTRL_RST;
			snap_pie <= iwc_pkg::PIE_RST;
			o_wake <= 1'b0;
		end else begin
			state <= next_state;
			snap_ctrl <= next_snap_ctrl;
			snap_pie <= next_snap_pie;
			o_wake <= next_wake;
		end
	end

	// ========================================================
	// Stack push and context restore toward the core.
	// Live watchdog and powerdown bits pass through, never the shadow ones.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_stack_push <= 1'b0;
			o_stack_pc <= '0;
			o_restore_valid <= 1'b0;
			o_ctx_restore <= '{default: iwc_pkg::CTX_RST};
		end else begin
			o_stack_push <= i_irq_entry; // RL9
			if (i_irq_entry) begin
				o_stack_pc <= i_return_pc; // RL9
			end
			o_restore_valid <= i_irq_exit && !i_irq_entry; // RL11
			if (i_irq_exit && !i_irq_entry) begin
				o_ctx_restore <= shadow; // RL11
				o_ctx_restore[iwc_pkg::CTX_STATUS] <=
					(shadow[iwc_pkg::CTX_STATUS] & iwc_pkg::STATUS_SAVE_MASK) |
					(i_ctx_live[iwc_pkg::CTX_STATUS] & ~iwc_pkg::STATUS_SAVE_MASK);
			end
		end
	end

	// ========================================================
	// Checks.
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_sleep_wake_glb;
		state == iwc_pkg::SLEEP && wake_src && ctrl[iwc_pkg::GLB_EN_BIT];
	endsequence
	sequence s_exit_taken;
		i_irq_exit && !i_irq_entry;
	endsequence

	chk_ext_edge_flag: assert property (ext_edge |=> ctrl[iwc_pkg::PIN_FLAG_BIT]) // RL7
		else $error("Pin edge did not set the pin flag.");
	// A settled level change toward the selected polarity must have raised an edge.
	chk_ext_edge_polarity: assert property (($past(pin_primed) && // RL6
		pin_level != $past(pin_level) && pin_level == $past(edge_sel)) |-> $past(ext_edge))
		else $error("Selected pin edge was not detected.");
	chk_pin_vector: assert property ((ctrl[iwc_pkg::GLB_EN_BIT] && // RL8 RL5
		ctrl[iwc_pkg::INTE_BIT] && ctrl[iwc_pkg::PIN_FLAG_BIT] &&
		state == iwc_pkg::RUN) |-> o_irq)
		else $error("Enabled pin flag did not request the vector.");
	chk_periph_gate: assert property ((o_irq && !ctrl[iwc_pkg::PER_EN_BIT]) |-> // RL14
		(ctrl[iwc_pkg::T0IE_BIT] && ctrl[iwc_pkg::T0IF_BIT]) ||
		(ctrl[iwc_pkg::INTE_BIT] && ctrl[iwc_pkg::PIN_FLAG_BIT]) ||
		(ctrl[iwc_pkg::CHG_EN_BIT] && ctrl[iwc_pkg::CHG_FLAG_BIT]))
		else $error("Peripheral request passed a clear peripheral enable.");
	chk_wake_needs_enable: assert property ((state == iwc_pkg::SLEEP && // RL1 RL2
		!snap_ctrl[iwc_pkg::INTE_BIT] && !snap_ctrl[iwc_pkg::CHG_EN_BIT] &&
		!snap_ctrl[iwc_pkg::PER_EN_BIT]) |=> !o_wake)
		else $error("Wake without a source enabled before sleep.");
	chk_wake_one_instr: assert property (s_sleep_wake_glb |=> // RL3 RL4
		(!o_irq && state == iwc_pkg::WAKE_ONE))
		else $error("Vector taken before the instruction after sleep.");
	chk_wake_resume: assert property ((state == iwc_pkg::SLEEP && wake_src && // RL3
		!ctrl[iwc_pkg::GLB_EN_BIT]) |=> (o_wake && state == iwc_pkg::RUN))
		else $error("Wake with global enable clear did not resume.");
	chk_stack_push: assert property (i_irq_entry |=> (o_stack_push && // RL9
		o_stack_pc == $past(i_return_pc)))
		else $error("Return address was not pushed on entry.");
	chk_shadow_save: assert property (i_irq_entry |=> // RL10
		(shadow[iwc_pkg::CTX_WORK] == $past(i_ctx_live[iwc_pkg::CTX_WORK]) &&
		(shadow[iwc_pkg::CTX_STATUS] & ~iwc_pkg::STATUS_SAVE_MASK) == 8'h00))
		else $error("Context was not saved correctly on entry.");
	chk_restore_pulse: assert property (s_exit_taken |=> (o_restore_valid && // RL11
		o_ctx_restore[iwc_pkg::CTX_FSR1H] == $past(shadow[iwc_pkg::CTX_FSR1H])))
		else $error("Context was not restored from shadow on exit.");
	chk_shadow_write: assert property ((apb_wr && shadow_hit && !i_irq_entry && // RL12
		idx[2:0] == 3'h1) |=> shadow[iwc_pkg::CTX_WORK] == $past(i_pwdata[7:0]))
		else $error("Software write to shadow register was lost.");
endmodule

// ==== core/iwc_pkg.sv ====
// Purpose: Shared constants for the interrupt, wake and context block.
// Assumes: APB byte address is four times the register index.
// Notes: Rule summary follows.
// Function
// RL1 - Wake only from sources enabled before sleep.
// RL2 - Only clockless peripherals may wake the core.
// RL3 - After wake, vector if global enable set.
// RL4 - Execute one instruction before entering the handler.
// RL5 - Pin edge request gated by pin enable.
// RL6 - Edge select: set rising, clear falling.
// RL7 - Valid pin edge sets pin flag.
// RL8 - Pin flag with both enables redirects core.
// RL9 - Entry pushes return address on stack.
// RL10 - Entry saves context, except watchdog/powerdown bits.
// RL11 - Exit restores context from shadow copies.
// RL12 - Shadow copies readable and writable by software.
// RL13 - Peripheral enable bit layout, bit 2 zero.
// RL14 - Peripheral requests need peripheral enable too.
// RL15 - Software clears handled flag before returning.
package iwc_pkg;
	// ========================================================
	// Register indices, address width and unmapped read value.
	localparam logic [11:0] IRQ_CTRL_IDX = 12'h30B;
	localparam logic [11:0] PIE_IDX = 12'h091;
	localparam logic [11:0] OPTION_IDX = 12'h095;
	localparam logic [11:0] SHADOW_IDX = 12'hFE8;
	localparam int ADDR_W = 14;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
	// ========================================================
	// Field positions of the interrupt control and option registers.
	localparam int GLB_EN_BIT = 7;
	localparam int PER_EN_BIT = 6;
	localparam int T0IE_BIT = 5;
	localparam int INTE_BIT = 4;
	localparam int CHG_EN_BIT = 3;
	localparam int T0IF_BIT = 2;
	localparam int PIN_FLAG_BIT = 1;
	localparam int CHG_FLAG_BIT = 0;
	localparam logic [7:0] FLAG_MASK = 8'h07;
	localparam int EDGE_BIT = 6;
	// ========================================================
	// Reset values and implemented bits.
	localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
	localparam logic [7:0] PIE_RST = 8'h00;
	localparam logic [7:0] PIE_MASK = 8'hFB;
	localparam logic EDGE_RST = 1'b0;
	// ========================================================
	// Context slots, shadow index order.
	localparam int CTX_N = 8;
	localparam int CTX_STATUS = 0;
	localparam int CTX_WORK = 1;
	localparam int CTX_BANK = 2;
	localparam int CTX_PCHI = 3;
	localparam int CTX_FSR0L = 4;
	localparam int CTX_FSR0H = 5;
	localparam int CTX_FSR1L = 6;
	localparam int CTX_FSR1H = 7;
	// Status bits 4 and 3 hold watchdog expiry and powerdown.
	localparam logic [7:0] STATUS_SAVE_MASK = 8'hE7;
	localparam logic [7:0] CTX_RST = 8'h00;
	localparam int PC_W = 15;
	typedef enum logic [1:0] {RUN, SLEEP, WAKE_ONE} iwc_state_e;
endpackage

// ==== verification/iwc_core_model.sv ====
// Purpose: Behavioural core sequencer that faces the interrupt block.
// Assumes: It takes the vector on the cycle after it sees a request.
// Notes: The return address is a free-running count, so every entry pushes a fresh value.
`timescale 1ns/1ps
module iwc_core_model #(
	parameter int P_DONE_DLY = 3
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_arst_n,
	// From the block and the bench.
	input wire logic i_irq,
	input wire logic i_wake,
	input wire logic i_exit_req,
	// To the block.
	output logic o_irq_entry,
	output logic o_irq_exit,
	output logic o_instr_done,
	output logic [iwc_pkg::PC_W-1:0] o_return_pc
);
	// ========================================================
	// Sequencing.
	int cnt;
	// A request is taken once, since the global enable drops one cycle after the entry pulse.
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_irq_entry <= 1'b0;
			o_irq_exit <= 1'b0;
			o_instr_done <= 1'b0;
			o_return_pc <= '0;
			cnt <= 0;
		end else begin
			o_irq_entry <= i_irq && !o_irq_entry;
			o_irq_exit <= i_exit_req;
			o_return_pc <= o_return_pc + 1'b1;
			// The instruction after sleep finishes some cycles after the wake.
			o_instr_done <= (cnt == 1);
			if (i_wake) begin
				cnt <= P_DONE_DLY;
			end else if (cnt != 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule

// ==== verification/tb_iwc_core.sv ====
// Purpose: Self-checking bench for the interrupt, wake and context block.
// Assumes: APB reads are noted in a queue and checked by a monitor.
// Notes: Every wait is bounded; a timeout ends the run.
`timescale 1ns/1ps
module tb_iwc_core;
	// ========================================================
	// Signals.
	logic i_clk = 0, i_arst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
	logic [iwc_pkg::ADDR_W-1:0] i_paddr = '0;
	logic [31:0] i_pwdata = '0, o_prdata;
	logic o_pready, o_pslverr, i_ext_pin = 0, i_timer0_ovf = 0, i_pin_change = 0;
	logic [7:0] i_periph_flags = '0, sh_work, old_stat;
	logic i_sleep_enter = 0, exit_req = 0, i_irq_entry, i_irq_exit, i_instr_done;
	logic [iwc_pkg::PC_W-1:0] i_return_pc, o_stack_pc, pc_exp;
	logic [7:0] live [iwc_pkg::CTX_N];
	logic [7:0] o_ctx_restore [iwc_pkg::CTX_N];
	logic o_irq, o_sleeping, o_wake, o_stack_push, o_restore_valid;
	logic [2:0] ev;
	logic [32:0] notes [$];
	int n_mismatch = 0, comparisons = 0;
	localparam logic [11:0] CT = iwc_pkg::IRQ_CTRL_IDX, SH = iwc_pkg::SHADOW_IDX;
	// Free-running 50 MHz clock.
	always #10 i_clk = ~i_clk;
	assign ev = {o_restore_valid, o_wake, o_irq};
	iwc_core iwc_core_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_ext_pin(i_ext_pin),
		.i_timer0_ovf(i_timer0_ovf), .i_pin_change(i_pin_change), .i_periph_flags(i_periph_flags),
		.i_sleep_enter(i_sleep_enter), .i_instr_done(i_instr_done), .i_irq_entry(i_irq_entry),
		.i_return_pc(i_return_pc), .i_irq_exit(i_irq_exit), .i_ctx_live(live), .o_irq(o_irq),
		.o_sleeping(o_sleeping), .o_wake(o_wake), .o_stack_push(o_stack_push),
		.o_stack_pc(o_stack_pc), .o_restore_valid(o_restore_valid), .o_ctx_restore(o_ctx_restore));
	iwc_core_model iwc_core_model_i (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_irq(o_irq),
		.i_wake(o_wake), .i_exit_req(exit_req), .o_irq_entry(i_irq_entry),
		.o_irq_exit(i_irq_exit), .o_instr_done(i_instr_done), .o_return_pc(i_return_pc));
	// ========================================================
	// Reporting.
	task automatic check(input logic ok, input string msg);
		comparisons++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("FAIL %0t %s", $time, msg);
		end
	endtask
	task automatic close_out;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic timeout;
		n_mismatch++;
		$display("FAIL %0t wait ran out", $time);
		close_out();
	endtask
	// The monitor pairs each completed read with the oldest note and checks pushed addresses.
	always @(posedge i_clk) begin
		if (i_psel && i_penable && o_pready === 1'b1 && !i_pwrite) begin
			if (notes.size() == 0) check(1'b0, "read without note");
			else check({o_pslverr, o_prdata} === notes.pop_front(), "read data");
		end
		if (o_stack_push === 1'b1) check(o_stack_pc === pc_exp, "pushed address");
		if (i_irq_entry) pc_exp <= i_return_pc;
	end
	// ========================================================
	// Drivers.
	// The request is held until pready is seen high, then released.
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
		input logic [32:0] exp);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= {idx, 2'b00};
		i_pwdata <= 32'(d);
		if (!w) notes.push_back(exp);
		@(posedge i_clk);
		i_penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge i_clk);
			if (o_pready === 1'b1) break;
		end
		if (k == 20) timeout();
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, '0);
	endtask
	task automatic rd(input logic [11:0] idx, input logic [7:0] e, input logic err = 1'b0);
		apb(1'b0, idx, 8'h00, {err, 24'h00_0000, e});
	endtask
	// Moves the pin, then leaves time for the synchroniser and the flag.
	task automatic pin(input logic v);
		@(posedge i_clk);
		i_ext_pin <= v;
		repeat (8) @(posedge i_clk);
	endtask
	task automatic leave_isr;
		@(posedge i_clk);
		exit_req <= 1'b1;
		@(posedge i_clk);
		exit_req <= 1'b0;
	endtask
	// Looks for an event for n cycles; it must come, or must not.
	task automatic watch(input int sel, input int n, input logic must);
		int k;
		for (k = 0; k < n; k++) begin
			@(posedge i_clk);
			#1;
			if (ev[sel] === 1'b1) break;
		end
		if (must && k == n) timeout();
		if (!must) check(k == n, "unexpected event");
	endtask
	// ========================================================
	// Main sequence.
	initial begin
		void'($urandom(32'hbecd));
		for (int i = 0; i < iwc_pkg::CTX_N; i++) live[i] <= 8'($urandom());
		repeat (6) @(posedge i_clk);
		i_arst_n <= 1'b1;
		rd(CT, iwc_pkg::IRQ_CTRL_RST);
		rd(iwc_pkg::PIE_IDX, iwc_pkg::PIE_RST);
		rd(12'h300, 8'h00, 1'b1);
		wr(iwc_pkg::PIE_IDX, 8'hFF);
		rd(iwc_pkg::PIE_IDX, 8'hFB);
		$display("test registers done");
		// Rising edges first, then falling edges.
		wr(iwc_pkg::OPTION_IDX, 8'h40);
		wr(CT, 8'h10);
		pin(1'b1);
		rd(CT, 8'h12);
		wr(CT, 8'h12);
		pin(1'b0);
		rd(CT, 8'h10);
		wr(iwc_pkg::OPTION_IDX, 8'h00);
		pin(1'b1);
		rd(CT, 8'h10);
		pin(1'b0);
		rd(CT, 8'h12);
		wr(CT, 8'h80);
		watch(0, 6, 1'b0);
		wr(CT, 8'h90);
		watch(0, 6, 1'b1);
		repeat (4) @(posedge i_clk);
		old_stat = live[0];
		rd(SH, live[0] & iwc_pkg::STATUS_SAVE_MASK);
		rd(SH + 12'd1, live[1]);
		sh_work = 8'($urandom());
		wr(SH + 12'd1, sh_work);
		@(posedge i_clk);
		live[0] <= 8'($urandom());
		live[1] <= ~live[1];
		wr(CT, 8'h12);
		leave_isr();
		watch(2, 8, 1'b1);
		check(o_ctx_restore[1] === sh_work, "restored working register");
		check(o_ctx_restore[0] === ((old_stat & iwc_pkg::STATUS_SAVE_MASK) |
			(live[0] & ~iwc_pkg::STATUS_SAVE_MASK)), "restored status");
		$display("test pin and context done");
		// A peripheral request needs its own enable and the peripheral enable.
		wr(iwc_pkg::PIE_IDX, 8'h02);
		@(posedge i_clk);
		i_periph_flags <= 8'h02;
		watch(0, 6, 1'b0);
		wr(CT, 8'hC0);
		watch(0, 6, 1'b1);
		@(posedge i_clk);
		i_periph_flags <= 8'h00;
		leave_isr();
		watch(2, 8, 1'b1);
		$display("test peripheral gate done");
		// Sleep: late enables, clocked sources and timer0 must not wake.
		wr(iwc_pkg::PIE_IDX, 8'h10);
		wr(CT, 8'hF0);
		@(posedge i_clk);
		i_sleep_enter <= 1'b1;
		@(posedge i_clk);
		i_sleep_enter <= 1'b0;
		i_periph_flags <= 8'h10;
		wr(CT, 8'hF8);
		@(posedge i_clk);
		i_pin_change <= 1'b1;
		i_timer0_ovf <= 1'b1;
		@(posedge i_clk);
		i_pin_change <= 1'b0;
		i_timer0_ovf <= 1'b0;
		watch(1, 8, 1'b0);
		check(o_sleeping === 1'b1, "asleep");
		pin(1'b1);
		i_ext_pin <= 1'b0;
		watch(1, 10, 1'b1);
		check(o_irq === 1'b0, "irq during wake instruction");
		watch(0, 2, 1'b0);
		watch(0, 10, 1'b1);
		$display("test sleep done");
		// Wake with the global enable clear must resume at once, with no held vector.
		wr(CT, 8'h17);
		@(posedge i_clk);
		i_sleep_enter <= 1'b1;
		@(posedge i_clk);
		i_sleep_enter <= 1'b0;
		pin(1'b1);
		i_ext_pin <= 1'b0;
		watch(1, 10, 1'b1);
		check(o_sleeping === 1'b0, "awake after wake");
		// Enabling now must vector before the model's instruction would finish.
		wr(CT, 8'h90);
		watch(0, 1, 1'b1);
		$display("test resume done");
		close_out();
	end
endmodule
